// file: logic/sfb_bank1.sv
// Bank-one special register map behind an AXI4-Lite slave.
`timescale 1ns/1ps

// Operation
// - Branch loads holding register into PC upper
// - PC upper five bits have no bus path
// - Unimplemented locations and bits read zero
// - Reduced-pin variant drops port D/E direction
// - Pin and watchdog resets are non-power-up
module sfb_bank1 #(
   parameter bit REDUCED_PIN = 1'b0       // Reduced-pin package variant
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic external_reset_n,
   input wire logic watchdog_timeout,
   input wire logic branch_exec,
   input wire logic [7:0] branch_low,
   input wire sfb_pkg::sfb_sts_t periph_sts,
   input wire logic [sfb_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic [2:0] s_axi_awprot,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [sfb_pkg::DATA_W-1:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [sfb_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic [2:0] s_axi_arprot,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [sfb_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   output sfb_pkg::sfb_cfg_t cfg,
   output logic [12:0] program_counter
);

   ////////////////////////////////////////////////////////////////////////
   // Reset pin synchroniser and non-power-up reset

   logic ext_s1_r;         // First stage, read by second stage only
   logic ext_s2_r;         // Synchronised reset pin level
   logic ext_s1_nxt;
   logic ext_s2_nxt;
   logic warm_rst;         // Non-power-up reset in effect

   // Pin is asynchronous, so two flops before any use
   always_comb begin
      ext_s1_nxt = external_reset_n;
      ext_s2_nxt = ext_s1_r;
   end

   // Idle high so a power-up does not look like a pin reset
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ext_s1_r <= 1'b1;
         ext_s2_r <= 1'b1;
      end else begin
         ext_s1_r <= ext_s1_nxt;
         ext_s2_r <= ext_s2_nxt;
      end
   end

   // Pin or watchdog, distinct from power-up reset
   assign warm_rst = !ext_s2_r || watchdog_timeout;

   ////////////////////////////////////////////////////////////////////////
   // Bus handshake state

   logic aw_held_r, aw_held_nxt;      // Write address captured
   logic w_held_r, w_held_nxt;        // Write data captured
   logic [7:0] waddr_r, waddr_nxt;    // Captured write index
   logic [7:0] wdata_r, wdata_nxt;    // Captured low data byte
   logic wlane_r, wlane_nxt;          // Low byte lane enabled
   logic bvalid_r, bvalid_nxt;
   logic rvalid_r, rvalid_nxt;
   logic [7:0] rdata_r, rdata_nxt;    // Only the low byte carries data
   logic wr_do;                       // Write commits this cycle
   logic rd_do;                       // Read address taken this cycle
   logic [7:0] rd_val;                // Decoded read value

   // Commit only when both halves are in and no answer is pending
   assign wr_do = aw_held_r && w_held_r && !bvalid_r;
   assign rd_do = s_axi_arvalid && !rvalid_r;

   // Capture address and data in either order
   always_comb begin
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      waddr_nxt = waddr_r;
      wdata_nxt = wdata_r;
      wlane_nxt = wlane_r;
      bvalid_nxt = bvalid_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      if (s_axi_awvalid && !aw_held_r) begin
         aw_held_nxt = 1'b1;
         waddr_nxt = s_axi_awaddr[9:2];
      end
      if (s_axi_wvalid && !w_held_r) begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata[7:0];
         wlane_nxt = s_axi_wstrb[0];
      end
      if (wr_do) begin
         aw_held_nxt = 1'b0;
         w_held_nxt = 1'b0;
         bvalid_nxt = 1'b1;
      end else if (bvalid_r && s_axi_bready) begin
         bvalid_nxt = 1'b0;
      end
      if (rd_do) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = rd_val;
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_nxt = 1'b0;
      end
   end

   // Bus state is kept across warm resets; only power-up clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         waddr_r <= 8'h00;
         wdata_r <= 8'h00;
         wlane_r <= 1'b0;
         bvalid_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 8'h00;
      end else begin
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         waddr_r <= waddr_nxt;
         wdata_r <= wdata_nxt;
         wlane_r <= wlane_nxt;
         bvalid_r <= bvalid_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   // Outputs straight from flops
   assign s_axi_awready = !aw_held_r;
   assign s_axi_wready = !w_held_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = sfb_pkg::RESP_OKAY;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rresp = sfb_pkg::RESP_OKAY;
   assign s_axi_rdata = {24'h00_0000, rdata_r};

   ////////////////////////////////////////////////////////////////////////
   // Data memory behind the indirect window

   logic [7:0] dmem [0:255];          // Byte store seen through the window
   logic mem_we;                      // Window write strobe

   // Window has no storage of its own
   assign mem_we = wr_do && wlane_r && (waddr_r == sfb_pkg::IDX_INDIRECT);

   // No reset: contents survive every reset like real RAM
   always_ff @(posedge aclk) begin
      if (mem_we) begin
         dmem[cfg.pointer] <= wdata_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Register file and program counter

   sfb_pkg::sfb_cfg_t cfg_r, cfg_nxt, cfg_rst;
   logic [7:0] pcl_r, pcl_nxt;        // Program counter low byte
   logic [4:0] pcu_r, pcu_nxt;        // Upper bits, no bus path
   logic sw_we;                       // Effective register write

   assign sw_we = wr_do && wlane_r;

   // Reset image shared by power-up and warm reset
   always_comb begin
      cfg_rst = '0;
      cfg_rst.option = sfb_pkg::RST_OPTION;
      cfg_rst.status = sfb_pkg::RST_STATUS;
      cfg_rst.pointer = sfb_pkg::RST_POINTER;
      cfg_rst.dir_a = sfb_pkg::RST_DIR_A;
      cfg_rst.dir_b = sfb_pkg::RST_DIR_8;
      cfg_rst.dir_c = sfb_pkg::RST_DIR_8;
      // Missing ports hold zero on the small package
      cfg_rst.dir_d = REDUCED_PIN ? sfb_pkg::RST_ZERO : sfb_pkg::RST_DIR_8;
      cfg_rst.dir_e = REDUCED_PIN ? sfb_pkg::RST_ZERO : sfb_pkg::RST_DIR_E;
      cfg_rst.t2per = sfb_pkg::RST_T2PER;
      cfg_rst.pwrflg = sfb_pkg::RST_ZERO;
   end

   // Software writes, warm reset and branch load
   always_comb begin
      cfg_nxt = cfg_r;
      pcl_nxt = pcl_r;
      pcu_nxt = pcu_r;
      if (sw_we) begin
         unique case (waddr_r)
            sfb_pkg::IDX_OPTION: cfg_nxt.option = wdata_r;
            sfb_pkg::IDX_PCL: pcl_nxt = wdata_r;
            sfb_pkg::IDX_STATUS: cfg_nxt.status =
               (cfg_r.status & ~sfb_pkg::WM_STATUS) |
               (wdata_r & sfb_pkg::WM_STATUS);
            sfb_pkg::IDX_POINTER: cfg_nxt.pointer = wdata_r;
            sfb_pkg::IDX_DIR_A: cfg_nxt.dir_a = wdata_r & sfb_pkg::WM_DIR_A;
            sfb_pkg::IDX_DIR_B: cfg_nxt.dir_b = wdata_r;
            sfb_pkg::IDX_DIR_C: cfg_nxt.dir_c = wdata_r;
            // Writes dropped on the small package
            sfb_pkg::IDX_DIR_D: begin
               if (!REDUCED_PIN) cfg_nxt.dir_d = wdata_r;
            end
            sfb_pkg::IDX_DIR_E: begin
               if (!REDUCED_PIN) begin
                  cfg_nxt.dir_e = wdata_r & sfb_pkg::WM_DIR_E;
               end
            end
            sfb_pkg::IDX_PCHOLD: cfg_nxt.pc_hold =
               wdata_r & sfb_pkg::WM_PCHOLD;
            sfb_pkg::IDX_INTCTL: cfg_nxt.intctl = wdata_r;
            sfb_pkg::IDX_PERIPHERAL_INT_ENABLE_1: cfg_nxt.peripheral_int_enable_1 = wdata_r;
            sfb_pkg::IDX_PERIPHERAL_INT_ENABLE_2: cfg_nxt.peripheral_int_enable_2 = wdata_r & sfb_pkg::WM_PERIPHERAL_INT_ENABLE_2;
            sfb_pkg::IDX_PWRFLG: cfg_nxt.pwrflg =
               wdata_r & sfb_pkg::WM_PWRFLG;
            sfb_pkg::IDX_T2PER: cfg_nxt.t2per = wdata_r;
            sfb_pkg::IDX_SSPADR: cfg_nxt.sspadr = wdata_r;
            sfb_pkg::IDX_SSPSTS: cfg_nxt.sspsts =
               wdata_r & sfb_pkg::WM_SSPSTS;
            sfb_pkg::IDX_TXCTL: cfg_nxt.txctl = wdata_r & sfb_pkg::WM_TXCTL;
            sfb_pkg::IDX_BAUD: cfg_nxt.baud = wdata_r;
            sfb_pkg::IDX_ADCFG: cfg_nxt.adcfg = wdata_r & sfb_pkg::WM_ADCFG;
            // Window and holes store nothing here
            default: cfg_nxt = cfg_r;
         endcase
      end
      // Branch beats a software write to the low byte in the same cycle
      if (branch_exec) begin
         pcl_nxt = branch_low;
         pcu_nxt = cfg_r.pc_hold[4:0];
      end
      // Warm reset: reset image, but the power flags are kept
      if (warm_rst) begin
         cfg_nxt = cfg_rst;
         cfg_nxt.pwrflg = cfg_r.pwrflg;
         cfg_nxt.status[sfb_pkg::STATUS_TIMEOUT_BIT] =
            !watchdog_timeout;
         pcl_nxt = sfb_pkg::RST_PCL;
         pcu_nxt = 5'h00;
      end
   end

   // Registers only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cfg_r <= '0;
         cfg_r.option <= sfb_pkg::RST_OPTION;
         cfg_r.status <= sfb_pkg::RST_STATUS;
         cfg_r.dir_a <= sfb_pkg::RST_DIR_A;
         cfg_r.dir_b <= sfb_pkg::RST_DIR_8;
         cfg_r.dir_c <= sfb_pkg::RST_DIR_8;
         cfg_r.dir_d <= REDUCED_PIN ? sfb_pkg::RST_ZERO : sfb_pkg::RST_DIR_8;
         cfg_r.dir_e <= REDUCED_PIN ? sfb_pkg::RST_ZERO : sfb_pkg::RST_DIR_E;
         cfg_r.t2per <= sfb_pkg::RST_T2PER;
         pcl_r <= sfb_pkg::RST_PCL;
         pcu_r <= 5'h00;
      end else begin
         cfg_r <= cfg_nxt;
         pcl_r <= pcl_nxt;
         pcu_r <= pcu_nxt;
      end
   end

   assign cfg = cfg_r;
   assign program_counter = {pcu_r, pcl_r};

   ////////////////////////////////////////////////////////////////////////
   // Read decode

   // Pure decode; holes and dropped bits give zero
   always_comb begin
      rd_val = 8'h00;
      unique case (s_axi_araddr[9:2])
         sfb_pkg::IDX_INDIRECT: rd_val = dmem[cfg_r.pointer];
         sfb_pkg::IDX_OPTION: rd_val = cfg_r.option;
         sfb_pkg::IDX_PCL: rd_val = pcl_r;
         sfb_pkg::IDX_STATUS: rd_val = cfg_r.status;
         sfb_pkg::IDX_POINTER: rd_val = cfg_r.pointer;
         sfb_pkg::IDX_DIR_A: rd_val = cfg_r.dir_a;
         sfb_pkg::IDX_DIR_B: rd_val = cfg_r.dir_b;
         sfb_pkg::IDX_DIR_C: rd_val = cfg_r.dir_c;
         sfb_pkg::IDX_DIR_D: rd_val = cfg_r.dir_d;
         sfb_pkg::IDX_DIR_E: begin
            // Parallel flags are absent with the port
            rd_val = cfg_r.dir_e;
            if (!REDUCED_PIN) begin
               rd_val[7:sfb_pkg::DIR_E_FLAG_LSB] =
                  periph_sts.parallel_flags;
            end
         end
         // Holding register only; the live upper bits stay hidden
         sfb_pkg::IDX_PCHOLD: rd_val = cfg_r.pc_hold;
         sfb_pkg::IDX_INTCTL: rd_val = cfg_r.intctl;
         sfb_pkg::IDX_PERIPHERAL_INT_ENABLE_1: rd_val = cfg_r.peripheral_int_enable_1;
         sfb_pkg::IDX_PERIPHERAL_INT_ENABLE_2: rd_val = cfg_r.peripheral_int_enable_2;
         sfb_pkg::IDX_PWRFLG: rd_val = cfg_r.pwrflg;
         sfb_pkg::IDX_T2PER: rd_val = cfg_r.t2per;
         sfb_pkg::IDX_SSPADR: rd_val = cfg_r.sspadr;
         sfb_pkg::IDX_SSPSTS: rd_val =
            cfg_r.sspsts | {2'b00, periph_sts.serial_flags};
         sfb_pkg::IDX_TXCTL: begin
            rd_val = cfg_r.txctl;
            rd_val[sfb_pkg::TXCTL_EMPTY_BIT] = periph_sts.tx_shift_empty;
         end
         sfb_pkg::IDX_BAUD: rd_val = cfg_r.baud;
         sfb_pkg::IDX_ADCFG: rd_val = cfg_r.adcfg;
         default: rd_val = 8'h00;
      endcase
   end

endmodule

// file: logic/sfb_pkg.sv
// Constants and carrier types for the bank-one special register map.
package sfb_pkg;

   // Bus geometry
   localparam int ADDR_W = 10;               // Byte address width
   localparam int DATA_W = 32;               // Bus data width

   // Register indices; byte address is four times the index
   localparam logic [7:0] IDX_INDIRECT = 8'h80;  // Indirect window
   localparam logic [7:0] IDX_OPTION = 8'h81;    // Option config
   localparam logic [7:0] IDX_PCL = 8'h82;       // Program counter low
   localparam logic [7:0] IDX_STATUS = 8'h83;    // Core status
   localparam logic [7:0] IDX_POINTER = 8'h84;   // Indirect pointer
   localparam logic [7:0] IDX_DIR_A = 8'h85;     // Port A direction
   localparam logic [7:0] IDX_DIR_B = 8'h86;     // Port B direction
   localparam logic [7:0] IDX_DIR_C = 8'h87;     // Port C direction
   localparam logic [7:0] IDX_DIR_D = 8'h88;     // Port D direction
   localparam logic [7:0] IDX_DIR_E = 8'h89;     // Port E dir, parallel
   localparam logic [7:0] IDX_PCHOLD = 8'h8a;    // PC upper holding
   localparam logic [7:0] IDX_INTCTL = 8'h8b;    // Interrupt control
   localparam logic [7:0] IDX_PERIPHERAL_INT_ENABLE_1 = 8'h8c;      // Peripheral enable 1
   localparam logic [7:0] IDX_PERIPHERAL_INT_ENABLE_2 = 8'h8d;      // Peripheral enable 2
   localparam logic [7:0] IDX_PWRFLG = 8'h8e;    // Power reset flags
   localparam logic [7:0] IDX_T2PER = 8'h92;     // Timer2 period
   localparam logic [7:0] IDX_SSPADR = 8'h93;    // Serial slave address
   localparam logic [7:0] IDX_SSPSTS = 8'h94;    // Serial status
   localparam logic [7:0] IDX_TXCTL = 8'h98;     // Uart transmit control
   localparam logic [7:0] IDX_BAUD = 8'h99;      // Baud divisor
   localparam logic [7:0] IDX_ADCFG = 8'h9f;     // Converter pin config

   // Values after power-up reset
   localparam logic [7:0] RST_OPTION = 8'hff;
   localparam logic [7:0] RST_PCL = 8'h00;
   localparam logic [7:0] RST_STATUS = 8'h18;
   localparam logic [7:0] RST_POINTER = 8'h00;
   localparam logic [7:0] RST_DIR_A = 8'h3f;
   localparam logic [7:0] RST_DIR_8 = 8'hff;
   localparam logic [7:0] RST_DIR_E = 8'h07;
   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] RST_T2PER = 8'hff;

   // Software-writable bits of each register
   localparam logic [7:0] WM_STATUS = 8'he7;   // Timeout, powerdown are RO
   localparam logic [7:0] WM_DIR_A = 8'h3f;
   localparam logic [7:0] WM_DIR_E = 8'h17;    // Flags 7:5 from port logic
   localparam logic [7:0] WM_PCHOLD = 8'h1f;
   localparam logic [7:0] WM_PERIPHERAL_INT_ENABLE_2 = 8'h01;
   localparam logic [7:0] WM_PWRFLG = 8'h03;
   localparam logic [7:0] WM_SSPSTS = 8'hc0;   // Low six are engine flags
   localparam logic [7:0] WM_TXCTL = 8'hf5;    // Shifter-empty bit is RO
   localparam logic [7:0] WM_ADCFG = 8'h07;

   // Field positions
   localparam int STATUS_TIMEOUT_BIT = 4;       // Cleared by watchdog
   localparam int DIR_E_FLAG_LSB = 5;           // Parallel flags in dir E
   localparam int TXCTL_EMPTY_BIT = 1;          // Shifter empty flag

   // Bus answer codes
   localparam logic [1:0] RESP_OKAY = 2'b00;

   // Configuration held for the peripherals
   typedef struct packed {
      logic [7:0] option;
      logic [7:0] status;
      logic [7:0] pointer;
      logic [7:0] dir_a;
      logic [7:0] dir_b;
      logic [7:0] dir_c;
      logic [7:0] dir_d;
      logic [7:0] dir_e;
      logic [7:0] pc_hold;
      logic [7:0] intctl;
      logic [7:0] peripheral_int_enable_1;
      logic [7:0] peripheral_int_enable_2;
      logic [7:0] pwrflg;
      logic [7:0] t2per;
      logic [7:0] sspadr;
      logic [7:0] sspsts;
      logic [7:0] txctl;
      logic [7:0] baud;
      logic [7:0] adcfg;
   } sfb_cfg_t;

   // Live flags from the peripherals, read-only to software
   typedef struct packed {
      logic [2:0] parallel_flags;   // Input full, output full, overflow
      logic [5:0] serial_flags;     // Serial engine status bits 5:0
      logic tx_shift_empty;         // Uart shifter empty
   } sfb_sts_t;

endpackage

// file: bench/sfb_bank1_properties.sv
// Concurrent checks on the bank-one register map ports.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module sfb_bank1_properties #(
   parameter bit REDUCED_PIN = 1'b0
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic external_reset_n,
   input wire logic watchdog_timeout,
   input wire logic branch_exec,
   input wire logic [7:0] branch_low,
   input wire logic [sfb_pkg::DATA_W-1:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire sfb_pkg::sfb_cfg_t cfg,
   input wire logic [12:0] program_counter
);
   // Pin history; a warm reset trails the pin by the sync delay
   logic [3:0] pin_hist_r;
   logic [3:0] pin_hist_nxt;
   logic quiet;
   // Shift in the pin level each cycle
   always_comb begin
      pin_hist_nxt = {pin_hist_r[2:0], external_reset_n};
   end
   // Cleared in reset, so checks wait until the history is known
   always_ff @(posedge aclk) begin
      pin_hist_r <= aresetn ? pin_hist_nxt : 4'h0;
   end
   assign quiet = (&pin_hist_r) && external_reset_n && !watchdog_timeout;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   ////////////////////////////////////////////////////////////////////
   branch_low_a: assert property (
      branch_exec && quiet |=> program_counter[7:0] == $past(branch_low))
      else $error("PC low byte not loaded by branch");
   branch_upper_a: assert property (
      branch_exec && quiet |=>
      program_counter[12:8] == $past(cfg.pc_hold[4:0]))
      else $error("PC upper bits not loaded from holding register");
   upper_hold_a: assert property (
      quiet && !branch_exec |=> $stable(program_counter[12:8]))
      else $error("PC upper bits changed without a branch");
   unused_bits_a: assert property (
      cfg.pc_hold[7:5] == 3'h0 && cfg.dir_a[7:6] == 2'h0 &&
      cfg.peripheral_int_enable_2[7:1] == 7'h00 && cfg.adcfg[7:3] == 5'h00 &&
      cfg.pwrflg[7:2] == 6'h00)
      else $error("Unimplemented register bit is set");
   rdata_upper_a: assert property (
      s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000)
      else $error("Read data above bit 7 not zero");
   watchdog_reload_a: assert property (
      watchdog_timeout |=> cfg.option == sfb_pkg::RST_OPTION &&
      !cfg.status[4] && program_counter == 13'h0000)
      else $error("Watchdog reset did not reload registers");
   pin_reload_a: assert property (
      (!external_reset_n && !watchdog_timeout) [*4] |=>
      cfg.option == sfb_pkg::RST_OPTION && cfg.status[4])
      else $error("Pin reset did not reload registers");
   reduced_dir_a: assert property (
      REDUCED_PIN |-> cfg.dir_d == 8'h00 && cfg.dir_e == 8'h00)
      else $error("Reduced variant holds port D or E direction");
   // Main scenarios reached
   cover property (branch_exec && quiet);
   cover property (watchdog_timeout);
   cover property (!external_reset_n [*4]);
endmodule

bind sfb_bank1 sfb_bank1_properties #(.REDUCED_PIN(REDUCED_PIN)) u_props (
   .aclk, .aresetn, .external_reset_n, .watchdog_timeout, .branch_exec,
   .branch_low, .s_axi_rdata, .s_axi_rvalid, .cfg, .program_counter
);

// file: bench/sfb_bank1_test.sv
// Self-checking bench for the bank-one special register map.
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////////
module sfb_bank1_test;
   logic aclk = 1'b0;                 // 200 MHz core clock
   logic aresetn = 1'b0;              // Power-up reset, held at start
   logic external_reset_n = 1'b1;
   logic watchdog_timeout = 1'b0;
   logic branch_exec = 1'b0;
   logic [7:0] branch_low = 8'h00;
   sfb_pkg::sfb_sts_t periph_sts = '{3'h5, 6'h2a, 1'h1}; // Live flags
   logic [sfb_pkg::ADDR_W-1:0] s_axi_awaddr = '0;
   logic [sfb_pkg::ADDR_W-1:0] s_axi_araddr = '0;
   logic [2:0] s_axi_awprot = 3'h0;   // Ignored by the map, still driven
   logic [2:0] s_axi_arprot = 3'h0;
   logic [31:0] s_axi_wdata = 32'h0000_0000;
   logic [3:0] s_axi_wstrb = 4'hf;    // Low lane off in one scenario
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   sfb_pkg::sfb_cfg_t cfg, cfg_red;   // Full and reduced-pin images
   logic [12:0] program_counter;
   int bad_count = 0;
   int checked = 0;
   // Reset image and hole locations, with the live flags folded in
   localparam logic [7:0] RI [0:11] = '{8'h81, 8'h83, 8'h85, 8'h89,
      8'h8a, 8'h8f, 8'h92, 8'h94, 8'h98, 8'h9a, 8'h9f, 8'h00};
   localparam logic [7:0] RV [0:11] = '{8'hff, 8'h18, 8'h3f, 8'ha7,
      8'h00, 8'h00, 8'hff, 8'h2a, 8'h02, 8'h00, 8'h00, 8'h00};
   // Write value and the masked value read back
   localparam logic [7:0] WI [0:8] = '{8'h85, 8'h8a, 8'h8d, 8'h9f,
      8'h8f, 8'h83, 8'h98, 8'h8e, 8'h94};
   localparam logic [7:0] WD [0:8] = '{8'hff, 8'hff, 8'hff, 8'hff,
      8'hff, 8'h00, 8'h00, 8'hff, 8'hff};
   localparam logic [7:0] WE [0:8] = '{8'h3f, 8'h1f, 8'h01, 8'h07,
      8'h00, 8'h18, 8'h02, 8'h03, 8'hea};

   always #2.5 aclk = ~aclk;
   ////////////////////////////////////////////////////////////////////
   sfb_bank1 #(.REDUCED_PIN(1'b0)) DUT (
      .aclk, .aresetn, .external_reset_n, .watchdog_timeout, .branch_exec,
      .branch_low, .periph_sts, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready, .cfg, .program_counter);
   // Reduced-pin twin shares every input; only its image is watched
   sfb_bank1 #(.REDUCED_PIN(1'b1)) DUT2 (
      .aclk, .aresetn, .external_reset_n, .watchdog_timeout, .branch_exec,
      .branch_low, .periph_sts, .s_axi_awaddr, .s_axi_awprot,
      .s_axi_awvalid, .s_axi_awready(), .s_axi_wdata, .s_axi_wstrb,
      .s_axi_wvalid, .s_axi_wready(), .s_axi_bresp(), .s_axi_bvalid(),
      .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
      .s_axi_arready(), .s_axi_rdata(), .s_axi_rresp(), .s_axi_rvalid(),
      .s_axi_rready, .cfg(cfg_red), .program_counter());
   ////////////////////////////////////////////////////////////////////
   // Compare and count
   task automatic chk(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // Bus write; each channel drops its valid at its own handshake edge
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      @(posedge aclk);
      s_axi_awaddr <= {idx, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, s_axi_bresp}, 32'h0000_0000);
   endtask
   // Bus read and compare against the expected byte
   task automatic rc(input logic [7:0] idx, input logic [7:0] exp);
      @(posedge aclk);
      s_axi_araddr <= {idx, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
      chk($sformatf("reg %h", idx), s_axi_rdata, {24'h00_0000, exp});
      chk("rresp", {30'h0, s_axi_rresp}, 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Reset image, holes, unmapped space and the reduced twin
   task automatic t_reset_image();
      for (int i = 0; i < 12; i++) rc(RI[i], RV[i]);
      chk("reduced dir d", {24'h0, cfg_red.dir_d}, 32'h0000_0000);
      chk("reduced dir e", {24'h0, cfg_red.dir_e}, 32'h0000_0000);
   endtask
   // Unimplemented and read-only bits stay as they were
   task automatic t_masks();
      for (int i = 0; i < 9; i++) begin
         wr(WI[i], WD[i]);
         rc(WI[i], WE[i]);
      end
      // Live flags are read through, never stored
      periph_sts <= '{3'h2, 6'h15, 1'h0};
      rc(8'h89, 8'h47);
      rc(8'h98, 8'h00);
   endtask
   // Window follows the pointer both ways
   task automatic t_indirect();
      wr(8'h84, 8'h10);
      wr(8'h80, 8'h5a);
      wr(8'h84, 8'h11);
      wr(8'h80, 8'ha5);
      rc(8'h80, 8'ha5);
      wr(8'h84, 8'h10);
      rc(8'h80, 8'h5a);
      // Low lane off: window write dropped, answer still okay
      s_axi_wstrb <= 4'he;
      s_axi_awprot <= 3'h1;
      s_axi_arprot <= 3'h1;
      wr(8'h80, 8'hff);
      s_axi_wstrb <= 4'hf;
      rc(8'h80, 8'h5a);
   endtask
   // One-cycle branch strobe
   task automatic branch(input logic [7:0] low);
      @(posedge aclk);
      branch_exec <= 1'b1;
      branch_low <= low;
      @(posedge aclk);
      branch_exec <= 1'b0;
      @(posedge aclk);
   endtask
   // Upper PC only moves on a branch
   task automatic t_branch();
      wr(8'h8a, 8'h15);
      branch(8'h3c);
      chk("pc", {19'h0, program_counter}, 32'h0000_153c);
      wr(8'h82, 8'h77);
      chk("pc upper", {27'h0, program_counter[12:8]}, 32'h15);
      wr(8'h8a, 8'h0a);
      chk("pc upper", {27'h0, program_counter[12:8]}, 32'h15);
      branch(8'hc3);
      chk("pc", {19'h0, program_counter}, 32'h0000_0ac3);
   endtask
   // Watchdog then pin reset; flags survive, timeout bit tells apart
   task automatic t_warm();
      wr(8'h81, 8'h00);
      @(posedge aclk);
      watchdog_timeout <= 1'b1;
      @(posedge aclk);
      watchdog_timeout <= 1'b0;
      rc(8'h81, 8'hff);
      rc(8'h83, 8'h08);
      rc(8'h8e, 8'h03);
      wr(8'h81, 8'h00);
      @(posedge aclk);
      external_reset_n <= 1'b0;
      repeat (6) @(posedge aclk);
      external_reset_n <= 1'b1;
      repeat (4) @(posedge aclk);
      rc(8'h81, 8'hff);
      rc(8'h83, 8'h18);
      chk("pc", {19'h0, program_counter}, 32'h0000_0000);
   endtask
   ////////////////////////////////////////////////////////////////////
   // Verdict and end of run
   task automatic end_sim();
      if (bad_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset_image();
      t_masks();
      t_indirect();
      t_branch();
      t_warm();
      end_sim();
   end
   // Hang guard, far beyond the few hundred cycles expected
   initial begin
      #20000;
      bad_count++;
      end_sim();
   end
endmodule
